/* File: src/amc_map.svh */
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH

// ****************************************************************
// serial frame layout
// ****************************************************************
`define AMC_ADDR_W 10
`define AMC_DATA_W 6
`define AMC_FRAME_BITS 5'h10
`define AMC_CNT_MAX 5'h1F

// ****************************************************************
// register addresses
// ****************************************************************
`define AMC_ADDR_OPR_LOW 10'h000
`define AMC_ADDR_OPR_HIGH 10'h001
`define AMC_ADDR_CTL 10'h006

// ****************************************************************
// reset values
// ****************************************************************
`define AMC_OPR_RESET 8'h00
`define AMC_CTL_RESET 6'h00

// ****************************************************************
// field positions
// ****************************************************************
`define AMC_OPR_PWR_LSB 0
`define AMC_OPR_PWR_MSB 1
`define AMC_OPR_BLK_BIT 2
`define AMC_OPR_LOW_MSB 5
`define AMC_OPR_HIGH_LSB 6
`define AMC_OPR_HIGH_MSB 7
`define AMC_CTL_STEER_LSB 0
`define AMC_CTL_STEER_MSB 2
`define AMC_CTL_GAIN_BIT 3
`define AMC_CTL_LATCH_BIT 4
`define AMC_CTL_HIZ_BIT 5

// ****************************************************************
// converter data path
// ****************************************************************
`define AMC_ADC_W 12

`endif

/* File: src/amc_pkg.sv */
`include "amc_map.svh"

package amc_pkg;

  typedef enum logic [1:0] {
    AMC_PWR_NORMAL,
    AMC_PWR_STANDBY1,
    AMC_PWR_STANDBY2,
    AMC_PWR_STANDBY3
  } amc_power_t;

  typedef enum logic [2:0] {
    AMC_STEER_OFF,
    AMC_STEER_MOSAIC_SEPARATE,
    AMC_STEER_VD_INTERLACED,
    AMC_STEER_MOSAIC_REPEAT,
    AMC_STEER_THREE_COLOUR,
    AMC_STEER_THREE_COLOUR_II,
    AMC_STEER_FOUR_COLOUR,
    AMC_STEER_FOUR_COLOUR_II
  } amc_steer_t;

  typedef enum logic [1:0] {
    AMC_SER_IDLE,
    AMC_SER_SHIFT
  } amc_ser_state_t;

  typedef struct packed {
    logic [2:0] sck_sync;
    logic [2:0] sl_sync;
    logic [2:0] sdata_sync;
    logic sck_level;
    logic sl_level;
    logic sdata_level;
    amc_ser_state_t ser_state;
    logic [15:0] shift;
    logic [4:0] bit_cnt;
    logic [7:0] operation_mode_word;
    logic [5:0] colour_output_control_word;
    logic [`AMC_ADC_W-1:0] data_out;
    logic data_oe;
  } amc_state_t;

endpackage

/* File: src/amc_top.sv */
`timescale 1ns/10ps
// Operation
// - operation word bits 5:0 at address 0, bits 7:6 at address 1, 10-bit address
// - power field bits 1:0: 0 normal, 1 to 3 standby states
// - operation bit 2 high disables black-level clamping
// - control word resets to zero; bits 2:0 select colour steering mode
// - control bit 3 high enables the per-pixel gain amplifier
// - control bit 4 low registers converter data on selected output edge
// - control bit 4 high makes output latch transparent
// - control bit 5 high places data outputs in high impedance

`include "amc_map.svh"

module amc_top
  import amc_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic SER_CLK_I,
  input wire logic SER_LOAD_N_I,
  input wire logic SER_DATA_I,
  input wire logic [`AMC_ADC_W-1:0] ADC_DATA_I,
  input wire logic DOUT_EDGE_I,
  output logic [1:0] POWER_STATE_SELECT_O,
  output logic BLACK_CLAMP_DISABLE_O,
  output logic [4:0] TEST_MODE_BITS_O,
  output logic [2:0] COLOUR_STEER_MODE_O,
  output logic PIXEL_GAIN_ENABLE_O,
  output logic OUTPUT_LATCH_BYPASS_O,
  output logic [`AMC_ADC_W-1:0] DATA_O,
  output logic DATA_OE_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  amc_state_t state_reg;
  amc_state_t state_next;

  logic sck_rise;
  logic sl_rise;
  logic sl_fall;
  logic [`AMC_ADDR_W-1:0] wr_addr;
  logic [`AMC_DATA_W-1:0] wr_data;
  logic frame_ok;
  logic sel_opr_low;
  logic sel_opr_high;
  logic sel_ctl;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    sck_rise = 1'b0;
    sl_rise = 1'b0;
    sl_fall = 1'b0;
    wr_addr = state_reg.shift[`AMC_ADDR_W-1:0];
    wr_data = state_reg.shift[15:`AMC_ADDR_W];
    frame_ok = 1'b0;
    sel_opr_low = 1'b0;
    sel_opr_high = 1'b0;
    sel_ctl = 1'b0;

    // three stages; a level counts once stages two and three agree
    state_next.sck_sync = {state_reg.sck_sync[1:0], SER_CLK_I};
    state_next.sl_sync = {state_reg.sl_sync[1:0], SER_LOAD_N_I};
    state_next.sdata_sync = {state_reg.sdata_sync[1:0], SER_DATA_I};
    if (state_reg.sck_sync[1] == state_reg.sck_sync[2])
    begin
      state_next.sck_level = state_reg.sck_sync[2];
    end
    if (state_reg.sl_sync[1] == state_reg.sl_sync[2])
    begin
      state_next.sl_level = state_reg.sl_sync[2];
    end
    if (state_reg.sdata_sync[1] == state_reg.sdata_sync[2])
    begin
      state_next.sdata_level = state_reg.sdata_sync[2];
    end

    sck_rise = state_next.sck_level & ~state_reg.sck_level;
    sl_rise = state_next.sl_level & ~state_reg.sl_level;
    sl_fall = ~state_next.sl_level & state_reg.sl_level;

    // ****************************************************************
    // address decode
    // ****************************************************************
    // exact match on all ten address bits; aliases never hit a register,
    // and an unmapped address selects nothing, so its frame is taken
    // and then ignored
    if (wr_addr == `AMC_ADDR_OPR_LOW)
    begin
      sel_opr_low = 1'b1;
    end
    else if (wr_addr == `AMC_ADDR_OPR_HIGH)
    begin
      sel_opr_high = 1'b1;
    end
    else if (wr_addr == `AMC_ADDR_CTL)
    begin
      sel_ctl = 1'b1;
    end

    // ****************************************************************
    // serial receiver: address then data, least significant bit first
    // ****************************************************************
    case (state_reg.ser_state)
      AMC_SER_IDLE:
      begin
        if (sl_fall)
        begin
          state_next.ser_state = AMC_SER_SHIFT;
          state_next.bit_cnt = 5'h00;
        end
      end
      AMC_SER_SHIFT:
      begin
        // data is sampled from its agreed level of the cycle before, one cycle
        // older than the clock level that makes the edge, so it keeps its setup relation
        if (sck_rise && !sl_rise)
        begin
          state_next.shift = {state_reg.sdata_level, state_reg.shift[15:1]};
          // the count stops at its ceiling so a runaway frame cannot
          // wrap round and look like a frame of the right length
          if (state_reg.bit_cnt != `AMC_CNT_MAX)
          begin
            state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
          end
        end
        if (sl_rise)
        begin
          state_next.ser_state = AMC_SER_IDLE;
          // a frame of any other length is dropped whole, so a glitch on
          // the serial clock cannot shift a half-written word into place
          frame_ok = (state_reg.bit_cnt == `AMC_FRAME_BITS);
          if (frame_ok && sel_opr_low)
          begin
            state_next.operation_mode_word[`AMC_OPR_LOW_MSB:0] = wr_data;
          end
          if (frame_ok && sel_opr_high)
          begin
            // only two data bits exist at this address; the rest are lost
            state_next.operation_mode_word[`AMC_OPR_HIGH_MSB:`AMC_OPR_HIGH_LSB] =
              wr_data[1:0];
          end
          if (frame_ok && sel_ctl)
          begin
            // the whole control word, steering field included, is replaced
            state_next.colour_output_control_word = wr_data;
          end
        end
      end
      default:
      begin
        state_next.ser_state = AMC_SER_IDLE;
      end
    endcase

    // ****************************************************************
    // converter output path
    // ****************************************************************
    if (state_reg.colour_output_control_word[`AMC_CTL_LATCH_BIT])
    begin
      // transparent: follows the converter every cycle, one flop late
      state_next.data_out = ADC_DATA_I;
    end
    else if (DOUT_EDGE_I)
    begin
      state_next.data_out = ADC_DATA_I;
    end
    // the enable lags control bit 5 by one cycle, like the data it guards
    state_next.data_oe = ~state_reg.colour_output_control_word[`AMC_CTL_HIZ_BIT];
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RSTN_I)
    begin
      state_reg <= '0;
      // load idles high; a filter that woke low would report a false
      // frame start right after reset
      state_reg.sl_sync <= 3'h7;
      state_reg.sl_level <= 1'b1;
      state_reg.ser_state <= AMC_SER_IDLE;
      state_reg.operation_mode_word <= `AMC_OPR_RESET;
      state_reg.colour_output_control_word <= `AMC_CTL_RESET;
      state_reg.data_oe <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs, all straight from the state flops
  // ****************************************************************
  always_comb
  begin
    POWER_STATE_SELECT_O =
      state_reg.operation_mode_word[`AMC_OPR_PWR_MSB:`AMC_OPR_PWR_LSB];
    BLACK_CLAMP_DISABLE_O = state_reg.operation_mode_word[`AMC_OPR_BLK_BIT];
    // test bits are passed on untouched; the host must keep them at 5'h02
    TEST_MODE_BITS_O = state_reg.operation_mode_word[7:3];
    COLOUR_STEER_MODE_O =
      state_reg.colour_output_control_word[`AMC_CTL_STEER_MSB:`AMC_CTL_STEER_LSB];
    PIXEL_GAIN_ENABLE_O =
      state_reg.colour_output_control_word[`AMC_CTL_GAIN_BIT];
    OUTPUT_LATCH_BYPASS_O =
      state_reg.colour_output_control_word[`AMC_CTL_LATCH_BIT];
    // converter data is one cycle behind the pins even when transparent
    DATA_O = state_reg.data_out;
    DATA_OE_O = state_reg.data_oe;
  end

endmodule

/* File: bench/amc_host.sv */
`timescale 1ns/10ps
// ****
// serial host
// ****
module amc_host
(
  input wire logic clk_i,
  output logic sck_o,
  output logic load_n_o,
  output logic sdata_o
);
  initial
  begin
    sck_o = 1'b0;
    load_n_o = 1'b1;
    sdata_o = 1'b0;
  end
  // lsb first, address then data; n below 16 makes a frame the device drops
  task automatic send(input logic [15:0] w, input int n);
    load_n_o = 1'b0;
    repeat (5) @(negedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      sdata_o = w[i];
      repeat (5) @(negedge clk_i);
      sck_o = 1'b1;
      repeat (5) @(negedge clk_i);
      sck_o = 1'b0;
    end
    repeat (5) @(negedge clk_i);
    load_n_o = 1'b1;
    sdata_o = ~sdata_o; // released line carries no meaning
    repeat (12) @(negedge clk_i);
  endtask
endmodule

/* File: bench/amc_top_assertions.sv */
`timescale 1ns/10ps
`include "amc_map.svh"
// ****
// port checks
// ****
module amc_top_assertions
  import amc_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic SER_LOAD_N_I,
  input wire logic [`AMC_ADC_W-1:0] ADC_DATA_I,
  input wire logic DOUT_EDGE_I,
  input wire logic [1:0] POWER_STATE_SELECT_O,
  input wire logic BLACK_CLAMP_DISABLE_O,
  input wire logic [4:0] TEST_MODE_BITS_O,
  input wire logic [2:0] COLOUR_STEER_MODE_O,
  input wire logic PIXEL_GAIN_ENABLE_O,
  input wire logic OUTPUT_LATCH_BYPASS_O,
  input wire logic [`AMC_ADC_W-1:0] DATA_O,
  input wire logic DATA_OE_O
);
  logic [13:0] flds;
  assign flds = {POWER_STATE_SELECT_O, BLACK_CLAMP_DISABLE_O, TEST_MODE_BITS_O,
    COLOUR_STEER_MODE_O, PIXEL_GAIN_ENABLE_O, OUTPUT_LATCH_BYPASS_O, DATA_OE_O};
  default clocking cb @(posedge REF_CLK_I); endclocking
  // writes land a few cycles after load rises, so 8 quiet cycles suffice
  sequence s_idle; SER_LOAD_N_I [*8]; endsequence
  sequence s_frame; !SER_LOAD_N_I [*8]; endsequence
  property p_rst; !RSTN_I |=> flds == 14'h0001; endproperty
  property p_rdat; !RSTN_I |=> DATA_O == 12'h000; endproperty
  property p_first; disable iff (!RSTN_I) $rose(RSTN_I) |-> flds == 14'h0001; endproperty
  property p_idle; disable iff (!RSTN_I) s_idle |=> $stable(flds); endproperty
  property p_frame; disable iff (!RSTN_I) s_frame |=> $stable(flds); endproperty
  property p_chg;
    disable iff (!RSTN_I) $changed(flds) |-> SER_LOAD_N_I && $past(SER_LOAD_N_I, 3);
  endproperty
  property p_hold;
    disable iff (!RSTN_I) !OUTPUT_LATCH_BYPASS_O && !DOUT_EDGE_I |=> $stable(DATA_O);
  endproperty
  property p_cap;
    disable iff (!RSTN_I) OUTPUT_LATCH_BYPASS_O || DOUT_EDGE_I |=> DATA_O == $past(ADC_DATA_I);
  endproperty
  a_rst: assert property (p_rst) else $error("fields not cleared");
  a_rdat: assert property (p_rdat) else $error("data not cleared");
  a_first: assert property (p_first) else $error("fields moved at release");
  a_idle: assert property (p_idle) else $error("field moved when idle");
  a_frame: assert property (p_frame) else $error("field moved in frame");
  a_chg: assert property (p_chg) else $error("field moved before load");
  a_hold: assert property (p_hold) else $error("latched data moved");
  a_cap: assert property (p_cap) else $error("data not captured");
endmodule

bind amc_top amc_top_assertions u_chk (
  .REF_CLK_I(REF_CLK_I),
  .RSTN_I(RSTN_I),
  .SER_LOAD_N_I(SER_LOAD_N_I),
  .ADC_DATA_I(ADC_DATA_I),
  .DOUT_EDGE_I(DOUT_EDGE_I),
  .POWER_STATE_SELECT_O(POWER_STATE_SELECT_O),
  .BLACK_CLAMP_DISABLE_O(BLACK_CLAMP_DISABLE_O),
  .TEST_MODE_BITS_O(TEST_MODE_BITS_O),
  .COLOUR_STEER_MODE_O(COLOUR_STEER_MODE_O),
  .PIXEL_GAIN_ENABLE_O(PIXEL_GAIN_ENABLE_O),
  .OUTPUT_LATCH_BYPASS_O(OUTPUT_LATCH_BYPASS_O),
  .DATA_O(DATA_O),
  .DATA_OE_O(DATA_OE_O)
);

/* File: bench/afe_mode_control_registers_tb.sv */
`timescale 1ns/10ps
module afe_mode_control_registers_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] adc = 12'h000;
  logic edg = 1'b0;
  logic sck, ld_n, sd, blk, gain, byp, oe;
  logic [1:0] pwr;
  logic [4:0] tst;
  logic [2:0] str;
  logic [11:0] dout, v;
  logic [31:0] r;
  logic [31:0] seed = 32'h49;
  logic [7:0] e_opr = 8'h00;
  logic [5:0] e_ctl = 6'h00;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  amc_host host (.clk_i(clk), .sck_o(sck), .load_n_o(ld_n), .sdata_o(sd));
  amc_top uut (.REF_CLK_I(clk), .RSTN_I(rstn), .SER_CLK_I(sck), .SER_LOAD_N_I(ld_n),
    .SER_DATA_I(sd), .ADC_DATA_I(adc), .DOUT_EDGE_I(edg), .POWER_STATE_SELECT_O(pwr),
    .BLACK_CLAMP_DISABLE_O(blk), .TEST_MODE_BITS_O(tst), .COLOUR_STEER_MODE_O(str),
    .PIXEL_GAIN_ENABLE_O(gain), .OUTPUT_LATCH_BYPASS_O(byp), .DATA_O(dout), .DATA_OE_O(oe));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // short frames and unmapped addresses leave the expectation alone
  function automatic void upd(input logic [9:0] a, input logic [5:0] d, input int n);
    if (n == 16 && a == 10'h000) e_opr[5:0] = d;
    if (n == 16 && a == 10'h001) e_opr[7:6] = d[1:0];
    if (n == 16 && a == 10'h006) e_ctl = d;
  endfunction
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t fields got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_data(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t data got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [5:0] d, input int n);
    host.send({d, a}, n);
    upd(a, d, n);
    cmp({4'h0, tst, blk, pwr}, {4'h0, e_opr});
    cmp({6'h0, ~oe, byp, gain, str}, {6'h0, e_ctl});
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    wr(10'h3FF, 6'h3F, 16);
    for (int p = 0; p < 4; p++)
      wr(10'h000, {3'h2, p[0] ^ p[1], p[1:0]}, 16);
    // test bits are set for one frame only, to prove where address 1 lands
    wr(10'h001, 6'h03, 16);
    wr(10'h001, 6'h3C, 16);
    for (int s = 0; s < 8; s++)
      wr(10'h006, {2'h0, s[0], s[2:0]}, 16);
    wr(10'h006, 6'h3F, 15);
    wr(10'h006, 6'h20, 16);
    repeat (6)
    begin
      r = xs();
      wr({7'h0, r[2:0]}, r[2:0] == 3'h0 ? {3'h2, r[6:4]} :
        r[2:0] == 3'h1 ? {r[9:6], 2'h0} : r[9:4], 16);
    end
    wr(10'h006, 6'h10, 16);
    repeat (4)
    begin
      r = xs();
      adc = r[11:0];
      @(negedge clk);
      cmp_data(dout, adc);
    end
    wr(10'h006, 6'h00, 16);
    r = xs();
    v = r[11:0];
    adc = v;
    edg = 1'b1;
    @(negedge clk);
    edg = 1'b0;
    r = xs();
    adc = r[11:0];
    @(negedge clk);
    cmp_data(dout, v);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    e_opr = 8'h00;
    e_ctl = 6'h00;
    // load idles a few cycles before the first frame after reset
    repeat (4) @(negedge clk);
    wr(10'h002, 6'h3F, 16);
    finish_test();
  end
endmodule
